// >>> verilog/uea_endpoint_ctrl.sv
// Contract
// - Setting the empty-packet bit makes the endpoint send a zero-length packet.
// - Writing one to halt-release clears the stall; the bit reads zero.
// - Isochronous DMA level: set means over 16 free bytes, clear over 32.
// - Halt-set stalls the endpoint; host transactions get stall until released.
// - Software sets buffer-ready when memory is prepared; no DMA before that.
// - Six interrupt enable bits in low positions, aligned with status bits.
// - Clear feature request for this endpoint sets the clear-feature flag.
// - A DMA system bus error for this endpoint sets the bus-error flag.
// - Finished programmed DMA transfer sets the DMA-complete flag.
// - Host change of the interface alternate setting sets the alternate flag.
// - A token addressed to this endpoint sets the token flag; here only while the endpoint is active.
// - Returning a stall to the host sets the stall flag.
// - Status register is read-only, resets to zero, ignores writes.
// - Clear register is write-only; a one clears the matching flag.
// - Control and enable registers read/write, reset zero, reserved bits zero.
//
`timescale 1ns/100ps
`default_nettype none
module uea_endpoint_ctrl (
    input wire logic sys_clk_in,
    input wire logic resetn_in,
    input wire logic wb_cyc_in,
    input wire logic wb_stb_in,
    input wire logic wb_we_in,
    input wire logic [31:0] wb_adr_in,
    input wire logic [3:0] wb_sel_in,
    input wire logic [31:0] wb_dat_in,
    output logic [31:0] wb_dat_out,
    output logic wb_ack_out,
    input wire logic clrfeat_evt_in,
    input wire logic buserr_evt_in,
    input wire logic dmadone_evt_in,
    input wire logic altset_evt_in,
    input wire logic token_evt_in,
    input wire logic zlp_done_in,
    input wire logic [uea_pkg::FIFO_CNT_W-1:0] fifo_free_in,
    output logic ep_active_out,
    output logic ep_halted_out,
    output logic ep_flush_out,
    output logic zlp_req_out,
    output logic dma_allow_out,
    output logic irq_out
);
    ////////////////////////////////////////////////////////////////////////
    // Bus decode.
    logic bus_req;
    logic wr_stb;
    logic rd_stb;
    logic byte0_wr;
    logic hit_control;
    logic hit_enable;
    logic hit_clear;
    logic hit_status;
    logic [uea_pkg::CTL_WIDTH-1:0] wdat_ctl;
    logic [uea_pkg::IRQ_WIDTH-1:0] wdat_irq;

    // Control and interrupt state.
    logic active;
    logic buffer_ready;
    logic iso_dma_level;
    logic halted;
    logic flush_pulse;
    uea_pkg::uea_zlp_state_t zlp_state;
    logic [uea_pkg::IRQ_WIDTH-1:0] irq_enable;
    logic [uea_pkg::IRQ_WIDTH-1:0] irq_flags;
    logic [uea_pkg::IRQ_WIDTH-1:0] irq_set;
    logic [uea_pkg::IRQ_WIDTH-1:0] irq_clear;
    logic stall_returned;
    logic level_reached;
    logic [31:0] next_rdata;

    // A request is served once; ack is high for exactly one cycle.
    assign bus_req = wb_cyc_in & wb_stb_in & ~wb_ack_out;
    assign wr_stb = bus_req & wb_we_in;
    assign rd_stb = bus_req & ~wb_we_in;
    assign byte0_wr = wr_stb & wb_sel_in[0];
    assign hit_control = (wb_adr_in == uea_pkg::ADDR_CONTROL);
    assign hit_enable = (wb_adr_in == uea_pkg::ADDR_IRQ_ENABLE);
    assign hit_clear = (wb_adr_in == uea_pkg::ADDR_IRQ_CLEAR);
    assign hit_status = (wb_adr_in == uea_pkg::ADDR_IRQ_STATUS);
    assign wdat_ctl = wb_dat_in[uea_pkg::CTL_WIDTH-1:0];
    assign wdat_irq = wb_dat_in[uea_pkg::IRQ_WIDTH-1:0];

    ////////////////////////////////////////////////////////////////////////
    // Acknowledge one cycle after the request, for mapped and unmapped addresses alike.
    always_ff @(posedge sys_clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
            wb_ack_out <= 1'b0;
        else
            wb_ack_out <= bus_req;
    end

    // Read multiplexer; write-only and unmapped locations read as zero.
    always_comb
    begin
        next_rdata = 32'h0000_0000;
        if (hit_control)
        begin
            next_rdata[uea_pkg::CTL_ACTIVE] = active;
            next_rdata[uea_pkg::CTL_BUFFER_READY] = buffer_ready;
            next_rdata[uea_pkg::CTL_HALT_SET] = halted;
            next_rdata[uea_pkg::CTL_ISO_DMA_LEVEL] = iso_dma_level;
            next_rdata[uea_pkg::CTL_SEND_EMPTY] = (zlp_state == uea_pkg::ZLP_BUSY);
        end
        else if (hit_enable)
            next_rdata[uea_pkg::IRQ_WIDTH-1:0] = irq_enable;
        else if (hit_status)
            next_rdata[uea_pkg::IRQ_WIDTH-1:0] = irq_flags;
    end

    // Read data is captured in the cycle the request is taken.
    always_ff @(posedge sys_clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
            wb_dat_out <= 32'h0000_0000;
        else if (rd_stb)
            wb_dat_out <= next_rdata;
    end

    ////////////////////////////////////////////////////////////////////////
    // Active bit and isochronous DMA level are plain read/write bits.
    always_ff @(posedge sys_clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            active <= uea_pkg::CTL_RESET[uea_pkg::CTL_ACTIVE];
            iso_dma_level <= uea_pkg::CTL_RESET[uea_pkg::CTL_ISO_DMA_LEVEL];
        end
        else if (byte0_wr && hit_control)
        begin
            active <= wdat_ctl[uea_pkg::CTL_ACTIVE];
            iso_dma_level <= wdat_ctl[uea_pkg::CTL_ISO_DMA_LEVEL];
        end
    end

    // Flush is a self-clearing strobe to the FIFO and the endpoint state.
    always_ff @(posedge sys_clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
            flush_pulse <= uea_pkg::CTL_RESET[uea_pkg::CTL_FLUSH];
        else
            flush_pulse <= byte0_wr & hit_control & wdat_ctl[uea_pkg::CTL_FLUSH];
    end

    // Buffer ready is set by software and dropped by a flush.
    always_ff @(posedge sys_clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
            buffer_ready <= uea_pkg::CTL_RESET[uea_pkg::CTL_BUFFER_READY];
        else if (flush_pulse)
            buffer_ready <= 1'b0;
        else if (byte0_wr && hit_control)
            buffer_ready <= wdat_ctl[uea_pkg::CTL_BUFFER_READY];
    end

    ////////////////////////////////////////////////////////////////////////
    // Stall state: release wins when both bits are written together,
    // so software can always get the endpoint out of a stall.
    always_ff @(posedge sys_clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
            halted <= uea_pkg::CTL_RESET[uea_pkg::CTL_HALT_SET];
        else if (flush_pulse)
            halted <= 1'b0;
        else if (byte0_wr && hit_control && wdat_ctl[uea_pkg::CTL_HALT_RELEASE])
            halted <= 1'b0;
        else if (byte0_wr && hit_control && wdat_ctl[uea_pkg::CTL_HALT_SET])
            halted <= 1'b1;
    end

    ////////////////////////////////////////////////////////////////////////
    // Empty packet request: held toward the link until it reports the packet sent.
    always_ff @(posedge sys_clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
            zlp_state <= uea_pkg::ZLP_IDLE;
        else if (flush_pulse)
            zlp_state <= uea_pkg::ZLP_IDLE;
        else
        begin
            case (zlp_state)
                uea_pkg::ZLP_IDLE:
                begin
                    if (byte0_wr && hit_control && wdat_ctl[uea_pkg::CTL_SEND_EMPTY])
                        zlp_state <= uea_pkg::ZLP_BUSY;
                end
                uea_pkg::ZLP_BUSY:
                begin
                    if (zlp_done_in)
                        zlp_state <= uea_pkg::ZLP_IDLE;
                end
                default:
                    zlp_state <= uea_pkg::ZLP_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Link-facing outputs; an inactive endpoint shows no stall, empty packet or DMA activity, but flush still pulses.
    assign ep_active_out = active;
    assign ep_halted_out = halted & active;
    assign ep_flush_out = flush_pulse;
    assign zlp_req_out = active & (zlp_state == uea_pkg::ZLP_BUSY) & ~halted;

    // DMA may start only with a ready buffer and enough FIFO space.
    assign level_reached = iso_dma_level ? (fifo_free_in > uea_pkg::ISO_LEVEL_LOW_BYTES)
                                         : (fifo_free_in > uea_pkg::ISO_LEVEL_HIGH_BYTES);
    assign dma_allow_out = active & buffer_ready & ~flush_pulse & level_reached;

    ////////////////////////////////////////////////////////////////////////
    // Interrupt enable register.
    always_ff @(posedge sys_clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
            irq_enable <= uea_pkg::IRQ_RESET;
        else if (byte0_wr && hit_enable)
            irq_enable <= wdat_irq;
    end

    // Event sources; a token to a stalled endpoint is answered with a stall.
    assign stall_returned = token_evt_in & active & halted;
    always_comb
    begin
        irq_set = '0;
        irq_set[uea_pkg::IRQ_CLRFEAT] = clrfeat_evt_in;
        irq_set[uea_pkg::IRQ_BUSERR] = buserr_evt_in;
        irq_set[uea_pkg::IRQ_DMADONE] = dmadone_evt_in;
        irq_set[uea_pkg::IRQ_ALTSET] = altset_evt_in;
        irq_set[uea_pkg::IRQ_TOKEN] = token_evt_in & active;
        irq_set[uea_pkg::IRQ_HALT] = stall_returned;
    end

    // Only a write of ones to the clear register removes flags.
    assign irq_clear = (byte0_wr && hit_clear) ? wdat_irq : '0;

    uea_flag_bank u_flags (
        .sys_clk_in(sys_clk_in),
        .resetn_in(resetn_in),
        .set_in(irq_set),
        .clear_in(irq_clear),
        .flags_out(irq_flags)
    );

    // Level interrupt from unmasked flags.
    assign irq_out = |(irq_flags & irq_enable);

    ////////////////////////////////////////////////////////////////////////
    // Checks on the block's own behaviour.
    default clocking cb @(posedge sys_clk_in);
    endclocking
    default disable iff (!resetn_in);

    a_halt_set_stalls: assert property (
        (byte0_wr && hit_control && wdat_ctl[uea_pkg::CTL_HALT_SET]
         && !wdat_ctl[uea_pkg::CTL_HALT_RELEASE] && !flush_pulse) |=> halted)
        else $error("Halt-set write did not stall the endpoint.");

    a_halt_release_clears: assert property (
        (byte0_wr && hit_control && wdat_ctl[uea_pkg::CTL_HALT_RELEASE]) |=> !halted)
        else $error("Halt-release write left the endpoint stalled.");

    a_release_reads_zero: assert property (
        (rd_stb && hit_control) |=> (wb_ack_out && !wb_dat_out[uea_pkg::CTL_HALT_RELEASE]))
        else $error("Halt-release bit read back as one.");

    a_empty_packet_req: assert property (
        (byte0_wr && hit_control && wdat_ctl[uea_pkg::CTL_SEND_EMPTY] && wdat_ctl[uea_pkg::CTL_ACTIVE]
         && !wdat_ctl[uea_pkg::CTL_HALT_SET] && (!halted || wdat_ctl[uea_pkg::CTL_HALT_RELEASE])
         && !flush_pulse && zlp_state == uea_pkg::ZLP_IDLE) |=> zlp_req_out)
        else $error("Empty packet request not raised after write.");

    a_iso_level_sel: assert property (
        (active && buffer_ready && !flush_pulse && iso_dma_level
         && fifo_free_in == uea_pkg::ISO_LEVEL_HIGH_BYTES) |-> dma_allow_out)
        else $error("DMA not allowed at low level with enough space.");

    a_iso_level_high: assert property (
        (!iso_dma_level && fifo_free_in <= uea_pkg::ISO_LEVEL_HIGH_BYTES) |-> !dma_allow_out)
        else $error("DMA allowed below the high level.");

    a_no_dma_unready: assert property (
        !buffer_ready |-> !dma_allow_out)
        else $error("DMA allowed without a ready buffer.");

    a_flush_restores: assert property (
        flush_pulse |=> (!halted && !buffer_ready && zlp_state == uea_pkg::ZLP_IDLE))
        else $error("Flush did not restore endpoint state.");

    a_inactive_silent: assert property (
        !active |-> (!zlp_req_out && !ep_halted_out && !dma_allow_out))
        else $error("Inactive endpoint shows link activity.");

    a_event_sets_flag: assert property (
        clrfeat_evt_in |=> irq_flags[uea_pkg::IRQ_CLRFEAT])
        else $error("Clear feature event did not set its flag.");

    a_buserr_flag: assert property (
        buserr_evt_in |=> irq_flags[uea_pkg::IRQ_BUSERR])
        else $error("Bus error event did not set its flag.");

    a_stall_flag: assert property (
        (token_evt_in && active && halted) |=> irq_flags[uea_pkg::IRQ_HALT] [*1] ##0 ep_halted_out)
        else $error("Returned stall did not set the stall flag.");

    a_status_ro: assert property (
        (byte0_wr && hit_status && irq_set == '0) |=> irq_flags == $past(irq_flags))
        else $error("Write to status register changed the flags.");

    a_clear_write: assert property (
        (byte0_wr && hit_clear && wdat_irq[uea_pkg::IRQ_TOKEN] && !irq_set[uea_pkg::IRQ_TOKEN])
        |=> !irq_flags[uea_pkg::IRQ_TOKEN])
        else $error("Clear write did not clear the token flag.");

    a_irq_follows: assert property (
        irq_out == |(irq_flags & irq_enable))
        else $error("Interrupt output disagrees with flags and enables.");

    a_ack_one_cycle: assert property (
        (wb_cyc_in && wb_stb_in && !wb_ack_out) |=> wb_ack_out ##1 !wb_ack_out)
        else $error("Bus acknowledge not a single cycle.");

    a_enable_readback: assert property (
        (rd_stb && hit_enable) |=> (wb_dat_out[31:uea_pkg::IRQ_WIDTH] == '0
                                    && wb_dat_out[uea_pkg::IRQ_WIDTH-1:0] == $past(irq_enable)))
        else $error("Enable register read back wrong.");

    a_dmadone_flag: assert property (
        dmadone_evt_in |=> irq_flags[uea_pkg::IRQ_DMADONE])
        else $error("DMA complete event did not set its flag.");

    a_altset_flag: assert property (
        altset_evt_in |=> irq_flags[uea_pkg::IRQ_ALTSET])
        else $error("Alternate setting event did not set its flag.");

    a_token_flag: assert property (
        (token_evt_in && active) |=> irq_flags[uea_pkg::IRQ_TOKEN])
        else $error("Token to an active endpoint did not set its flag.");

    a_clear_zero_keeps: assert property (
        (byte0_wr && hit_clear && !wdat_irq[uea_pkg::IRQ_CLRFEAT] && irq_flags[uea_pkg::IRQ_CLRFEAT])
        |=> irq_flags[uea_pkg::IRQ_CLRFEAT])
        else $error("Writing zero to a clear bit removed its flag.");

    a_reserved_zero: assert property (
        (rd_stb && (hit_control || hit_enable)) |=> (wb_dat_out[31:uea_pkg::CTL_WIDTH] == '0))
        else $error("Reserved bits read back as nonzero.");
endmodule : uea_endpoint_ctrl
`default_nettype wire

// >>> verilog/uea_pkg.sv
`default_nettype none
package uea_pkg;
    // Register byte addresses on the system bus.
    localparam logic [31:0] ADDR_CONTROL = 32'hfff0604c;
    localparam logic [31:0] ADDR_IRQ_ENABLE = 32'hfff06050;
    localparam logic [31:0] ADDR_IRQ_CLEAR = 32'hfff06054;
    localparam logic [31:0] ADDR_IRQ_STATUS = 32'hfff06058;

    // Control register field positions.
    localparam int CTL_ACTIVE = 0;
    localparam int CTL_FLUSH = 1;
    localparam int CTL_BUFFER_READY = 2;
    localparam int CTL_HALT_SET = 3;
    localparam int CTL_ISO_DMA_LEVEL = 4;
    localparam int CTL_HALT_RELEASE = 5;
    localparam int CTL_SEND_EMPTY = 6;
    localparam int CTL_WIDTH = 7;

    // Interrupt field positions, shared by enable, clear and status.
    localparam int IRQ_HALT = 0;
    localparam int IRQ_TOKEN = 1;
    localparam int IRQ_ALTSET = 2;
    localparam int IRQ_DMADONE = 3;
    localparam int IRQ_BUSERR = 4;
    localparam int IRQ_CLRFEAT = 5;
    localparam int IRQ_WIDTH = 6;

    // Reset values.
    localparam logic [CTL_WIDTH-1:0] CTL_RESET = 7'h00;
    localparam logic [IRQ_WIDTH-1:0] IRQ_RESET = 6'h00;

    // FIFO free space thresholds in bytes for isochronous DMA.
    localparam int FIFO_CNT_W = 8;
    localparam logic [FIFO_CNT_W-1:0] ISO_LEVEL_LOW_BYTES = 8'h10;
    localparam logic [FIFO_CNT_W-1:0] ISO_LEVEL_HIGH_BYTES = 8'h20;

    // Empty packet request sequencer states.
    typedef enum logic [1:0] {
        ZLP_IDLE = 2'b01,
        ZLP_BUSY = 2'b10
    } uea_zlp_state_t;
endpackage : uea_pkg
`default_nettype wire

// >>> verilog/uea_flag_bank.sv
`timescale 1ns/100ps
`default_nettype none
module uea_flag_bank (
    input wire logic sys_clk_in,
    input wire logic resetn_in,
    input wire logic [uea_pkg::IRQ_WIDTH-1:0] set_in,
    input wire logic [uea_pkg::IRQ_WIDTH-1:0] clear_in,
    output logic [uea_pkg::IRQ_WIDTH-1:0] flags_out
);
    ////////////////////////////////////////////////////////////////////////
    // One sticky flag per source; a set in the clearing cycle wins.
    genvar i;
    generate
        for (i = 0; i < uea_pkg::IRQ_WIDTH; i = i + 1)
        begin : g_flag
            logic flag;
            always_ff @(posedge sys_clk_in or negedge resetn_in)
            begin
                if (!resetn_in)
                    flag <= uea_pkg::IRQ_RESET[i];
                else if (set_in[i])
                    flag <= 1'b1;
                else if (clear_in[i])
                    flag <= 1'b0;
            end
            assign flags_out[i] = flag; // Each bit has its own process and a single driver.
        end
    endgenerate
endmodule : uea_flag_bank
`default_nettype wire

// >>> sim/uea_host_model.sv
`timescale 1ns/100ps
`default_nettype none
module uea_host_model (
    input wire logic sys_clk_in,
    input wire logic resetn_in,
    input wire logic send_token_in,
    input wire logic [3:0] zlp_delay_in,
    input wire logic zlp_req_in,
    output logic token_evt_out,
    output logic zlp_done_out
);
    logic [3:0] wait_cnt;

    ////////////////////////////////////////////////////////////////
    // A token from the host reaches the endpoint one cycle after the bench asks.
    always_ff @(posedge sys_clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
            token_evt_out <= 1'b0;
        else
            token_evt_out <= send_token_in;
    end

    // The link sends the empty packet after a chosen delay, then reports it once.
    always_ff @(posedge sys_clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            wait_cnt <= 4'h0;
            zlp_done_out <= 1'b0;
        end
        else
        begin
            zlp_done_out <= 1'b0;
            if (zlp_req_in && !zlp_done_out)
            begin
                if (wait_cnt == zlp_delay_in)
                begin
                    zlp_done_out <= 1'b1;
                    wait_cnt <= 4'h0;
                end
                else
                    wait_cnt <= wait_cnt + 4'h1;
            end
            else
                wait_cnt <= 4'h0;
        end
    end
endmodule : uea_host_model
`default_nettype wire

// >>> sim/uea_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module usb_endpoint_a_ctrl_irq_tb_top;
    typedef struct {logic [31:0] adr; logic [31:0] wdat; logic [31:0] exp;} uea_row_t;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [31:0] adr = 32'h0;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rdat;
    logic ack;
    logic [5:2] ev = 4'h0;
    logic tok = 1'b0;
    logic [3:0] zdly = 4'h0;
    logic [7:0] free = 8'h00;
    logic tok_evt, zdone, act, halted, flush, zreq, dma, irq;
    logic flush_seen = 1'b0;
    int errors = 0;
    int checks = 0;
    uea_row_t rows[5];
    logic [7:0] dctl[6] = '{8'h15, 8'h15, 8'h05, 8'h05, 8'h01, 8'h04};
    logic [7:0] dfree[6] = '{8'h11, 8'h10, 8'h21, 8'h20, 8'hff, 8'hff};
    logic dexp[6] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0};

    uea_endpoint_ctrl dut_u (.sys_clk_in(clk), .resetn_in(rstn), .wb_cyc_in(cyc), .wb_stb_in(stb),
        .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(4'hf), .wb_dat_in(wdat), .wb_dat_out(rdat),
        .wb_ack_out(ack), .clrfeat_evt_in(ev[5]), .buserr_evt_in(ev[4]), .dmadone_evt_in(ev[3]),
        .altset_evt_in(ev[2]), .token_evt_in(tok_evt), .zlp_done_in(zdone), .fifo_free_in(free),
        .ep_active_out(act), .ep_halted_out(halted), .ep_flush_out(flush), .zlp_req_out(zreq),
        .dma_allow_out(dma), .irq_out(irq));

    uea_host_model host_u (.sys_clk_in(clk), .resetn_in(rstn), .send_token_in(tok),
        .zlp_delay_in(zdly), .zlp_req_in(zreq), .token_evt_out(tok_evt), .zlp_done_out(zdone));

    ////////////////////////////////////////////////////////////////
    // Clock at 200 MHz and a flag that remembers any flush pulse.
    initial
    begin
        forever #2.5 clk = ~clk;
    end

    always @(posedge clk)
    begin
        if (flush === 1'b1)
            flush_seen <= 1'b1;
    end

    // Compares a value and counts the result.
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            errors++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    // One classic bus cycle, held until ack is sampled high.
    task automatic wb(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (ack !== 1'b1 && n < 50);
        if (n >= 50)
            chk(32'h0, 32'h1);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask : wb

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] q;
        wb(1'b1, a, d, q);
    endtask : wr

    task automatic rdc(input logic [31:0] a, input logic [31:0] exp);
        logic [31:0] q;
        wb(1'b0, a, 32'h0, q);
        chk(q, exp);
    endtask : rdc

    // Pulses one event input, or a host token when b is 1, then lets the flag land.
    task automatic pulse(input int b);
        @(posedge clk);
        if (b == 1)
            tok <= 1'b1;
        else
            ev[b] <= 1'b1;
        @(posedge clk);
        tok <= 1'b0;
        ev <= 4'h0;
        repeat (3) @(posedge clk);
    endtask : pulse

    task automatic print_verdict;
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : print_verdict

    // Cuts a hang short.
    initial
    begin
        #50000;
        errors++;
        print_verdict();
    end

    ////////////////////////////////////////////////////////////////
    // Main sequence.
    initial
    begin
        rows[0] = '{uea_pkg::ADDR_CONTROL, 32'hffffff95, 32'h15};
        rows[1] = '{uea_pkg::ADDR_IRQ_ENABLE, 32'hffffffff, 32'h3f};
        rows[2] = '{uea_pkg::ADDR_IRQ_STATUS, 32'hffffffff, 32'h0};
        rows[3] = '{uea_pkg::ADDR_IRQ_CLEAR, 32'hffffffff, 32'h0};
        rows[4] = '{32'hfff0605c, 32'hffffffff, 32'h0};
        repeat (4) @(posedge clk);
        rstn <= 1'b1;
        for (int i = 0; i < 4; i++)
            rdc(rows[i].adr, 32'h0);
        $display("reset values done");
        for (int i = 0; i < 5; i++)
        begin
            wr(rows[i].adr, rows[i].wdat);
            rdc(rows[i].adr, rows[i].exp);
        end
        chk(act, 1'b1);
        $display("register table done");
        for (int i = 2; i < 6; i++)
        begin
            pulse(i);
            rdc(uea_pkg::ADDR_IRQ_STATUS, 32'h1 << i);
            chk(irq, 1'b1);
            wr(uea_pkg::ADDR_IRQ_CLEAR, 32'h3f & ~(32'h1 << i));
            wr(uea_pkg::ADDR_IRQ_STATUS, 32'hffffffff);
            rdc(uea_pkg::ADDR_IRQ_STATUS, 32'h1 << i);
            wr(uea_pkg::ADDR_IRQ_CLEAR, 32'h1 << i);
            rdc(uea_pkg::ADDR_IRQ_STATUS, 32'h0);
            chk(irq, 1'b0);
        end
        wr(uea_pkg::ADDR_IRQ_ENABLE, 32'h0);
        pulse(4);
        chk(irq, 1'b0);
        wr(uea_pkg::ADDR_IRQ_ENABLE, 32'h10);
        chk(irq, 1'b1);
        wr(uea_pkg::ADDR_IRQ_CLEAR, 32'h3f);
        $display("event flags done");
        wr(uea_pkg::ADDR_CONTROL, 32'h09);
        chk(halted, 1'b1);
        pulse(1);
        rdc(uea_pkg::ADDR_IRQ_STATUS, 32'h03);
        wr(uea_pkg::ADDR_IRQ_CLEAR, 32'h3f);
        wr(uea_pkg::ADDR_CONTROL, 32'h21);
        chk(halted, 1'b0);
        rdc(uea_pkg::ADDR_CONTROL, 32'h01);
        pulse(1);
        rdc(uea_pkg::ADDR_IRQ_STATUS, 32'h02);
        wr(uea_pkg::ADDR_CONTROL, 32'h00);
        wr(uea_pkg::ADDR_IRQ_CLEAR, 32'h3f);
        pulse(1);
        rdc(uea_pkg::ADDR_IRQ_STATUS, 32'h0);
        $display("halt and token done");
        for (int k = 0; k < 2; k++)
        begin
            zdly <= (k == 0) ? 4'h0 : 4'h9;
            wr(uea_pkg::ADDR_CONTROL, 32'h41);
            chk(zreq, 1'b1);
            for (int n = 0; n < 30 && zreq === 1'b1; n++)
                @(posedge clk);
            chk(zreq, 1'b0);
            rdc(uea_pkg::ADDR_CONTROL, 32'h01);
        end
        $display("empty packet done");
        for (int i = 0; i < 6; i++)
        begin
            wr(uea_pkg::ADDR_CONTROL, {24'h0, dctl[i]});
            free <= dfree[i];
            repeat (2) @(posedge clk);
            chk(dma, dexp[i]);
        end
        $display("dma level done");
        wr(uea_pkg::ADDR_CONTROL, 32'h4d);
        chk(zreq, 1'b0);
        rdc(uea_pkg::ADDR_CONTROL, 32'h4d);
        wr(uea_pkg::ADDR_CONTROL, 32'h07);
        repeat (2) @(posedge clk);
        chk(flush_seen, 1'b1);
        chk(halted, 1'b0);
        chk(zreq, 1'b0);
        rdc(uea_pkg::ADDR_CONTROL, 32'h01);
        pulse(5);
        wr(uea_pkg::ADDR_IRQ_ENABLE, 32'h20);
        chk(irq, 1'b1);
        @(posedge clk);
        rstn <= 1'b0;
        repeat (4) @(posedge clk);
        rstn <= 1'b1;
        chk(irq, 1'b0);
        rdc(uea_pkg::ADDR_CONTROL, 32'h0);
        rdc(uea_pkg::ADDR_IRQ_STATUS, 32'h0);
        rdc(uea_pkg::ADDR_IRQ_ENABLE, 32'h0);
        $display("flush and reset done");
        print_verdict();
    end
endmodule : usb_endpoint_a_ctrl_irq_tb_top
`default_nettype wire
